// File: awsq_consts.vh
`ifndef AWSQ_CONSTS_VH
`define AWSQ_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AWSQ_CTRL     12'h000
`define AWSQ_STAT     12'h004
`define AWSQ_ISTAT    12'h008
`define AWSQ_IMASK    12'h00c
`define AWSQ_BLOCK    12'h010
`define AWSQ_AMP      12'h014
`define AWSQ_FREQ     12'h018
`define AWSQ_DC       12'h01c
`define AWSQ_TIME     12'h020
`define AWSQ_ANGLE    12'h024
`define AWSQ_COMMIT   12'h028
`define AWSQ_SETPT    12'h02c
// ----------------------------------------
// field positions
// ----------------------------------------
`define AWSQ_CTRL_START 0
`define AWSQ_CTRL_STOP  1
`define AWSQ_CTRL_VOLT  2
`define AWSQ_IRQ_DONE   0
`define AWSQ_IRQ_REJ    1
`define AWSQ_IRQ_ALM    2
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define AWSQ_BLOCK_RST  32'h0001_0101
`define AWSQ_NPTS       7'd99
`define AWSQ_MAX_CYC    10'd999
`define AWSQ_MAX_FREQ   14'd10000
`define AWSQ_MAX_ANG    9'd359
`define AWSQ_TIME_MIN   29'd1
`define AWSQ_TIME_MAX   29'd360000000
`define AWSQ_TIME_DEF   29'd10
`define AWSQ_RATIO_DEN  40'd100000
`define AWSQ_RATIO_NUM  40'd93
// ----------------------------------------
// timing and phase scaling
// ----------------------------------------
`define AWSQ_CLK_NS     10
`define AWSQ_SAMPLE_NS  100000
`define AWSQ_FRQ_TO_PH  16'd53687
`define AWSQ_ANG_TO_PH  24'd11930465
`define AWSQ_SIN_CORR   16'd7373
`endif

// File: awsq_top.v
// How it works
// - ninety-nine points, same parameter set each
// - block repeats 1..999 times or forever
// - whole run drives one quantity only
// - dc ramp plus shaped sine per point
// - zero start/end frequency disables sine
// - amplitudes limited to half nominal
// - frequencies limited to 10000 Hz
// - sine starts at programmed angle 0..359
// - dc stays within amplitude margins
// - point time 0.1 ms to 36000 s
// - reject frequency slope below 9.3
// - reject amplitude change too small
// - first/last point select the block
// - each repetition restarts from first point
// - points run in ascending order
// - alarm halts run, output off, reported
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "awsq_consts.vh"
module awsq_top #(
    parameter        SAMPLE_CYC = `AWSQ_SAMPLE_NS / `AWSQ_CLK_NS,
    parameter [15:0] NOM_VOLT   = 16'hffff,
    parameter [15:0] NOM_CURR   = 16'hffff
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // device alarm
    input  wire        i_alarm,
    // setpoint to the power stage, and interrupt
    output reg  [15:0] o_setpoint,
    output wire        o_sel_voltage,
    output wire        o_output_on,
    output wire        o_irq
);
// ----------------------------------------
// state and storage
// ----------------------------------------
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_LOAD = 2'd1;
localparam [1:0] ST_RUN  = 2'd2;

reg  [1:0]   st_r;
reg          volt_r;
reg  [6:0]   first_r;
reg  [6:0]   last_r;
reg  [9:0]   cyc_r;
reg  [2:0]   istat_r;
reg  [2:0]   imask_r;
reg  [31:0]  stg_amp_r;
reg  [31:0]  stg_frq_r;
reg  [31:0]  stg_dc_r;
reg  [28:0]  stg_time_r;
reg  [8:0]   stg_ang_r;
reg  [129:0] mem [0:98];
reg  [6:0]   pt_r;
reg  [9:0]   done_cyc_r;
reg  [28:0]  smp_r;
reg  [31:0]  tick_r;
reg  [1:0]   dsel_r;
reg  [5:0]   dcnt_r;
reg  [29:0]  drem_r;
reg  [31:0]  dquo_r;
reg  [32:0]  dc_inc_r;
reg  [32:0]  amp_inc_r;
reg  [32:0]  frq_inc_r;
reg  [32:0]  dc_acc_r;
reg  [32:0]  amp_acc_r;
reg  [32:0]  frq_acc_r;
reg  [31:0]  ph_r;
integer      i;
// ----------------------------------------
// bus decode
// ----------------------------------------
wire        wr_w   = i_psel & i_penable & i_pwrite;
wire        idle_w = (st_r == ST_IDLE);
// the map is dense and word aligned up to the setpoint readback
wire        hit_w  = (i_paddr <= `AWSQ_SETPT) & (i_paddr[1:0] == 2'b00);
assign o_pready  = 1'b1;
assign o_pslverr = i_psel & i_penable & ~hit_w;
wire wr_ctrl   = wr_w & (i_paddr == `AWSQ_CTRL);
wire wr_block  = wr_w & (i_paddr == `AWSQ_BLOCK);
wire wr_commit = wr_w & (i_paddr == `AWSQ_COMMIT);
wire start_w   = wr_ctrl & i_pwdata[`AWSQ_CTRL_START];
wire stop_w    = wr_ctrl & i_pwdata[`AWSQ_CTRL_STOP];
// ----------------------------------------
// setting checks
// ----------------------------------------
// one quantity
wire [15:0] nom_w = volt_r ? NOM_VOLT : NOM_CURR;
wire [15:0] s_as  = stg_amp_r[15:0];
wire [15:0] s_ae  = stg_amp_r[31:16];
wire [13:0] s_fs  = stg_frq_r[13:0];
wire [13:0] s_fe  = stg_frq_r[29:16];
wire [15:0] s_ds  = stg_dc_r[15:0];
wire [15:0] s_de  = stg_dc_r[31:16];
wire [13:0] s_df  = (s_fe >= s_fs) ? s_fe - s_fs : s_fs - s_fe;
wire [15:0] s_da  = (s_ae >= s_as) ? s_ae - s_as : s_as - s_ae;
wire ok_amp  = (s_as <= {1'b0, nom_w[15:1]}) & (s_ae <= {1'b0, nom_w[15:1]});
wire ok_frq  = (s_fs <= `AWSQ_MAX_FREQ) & (s_fe <= `AWSQ_MAX_FREQ);
wire ok_ang  = (stg_ang_r <= `AWSQ_MAX_ANG);
wire ok_dc   = (s_ds >= s_as) & (s_ds <= nom_w - s_as)
             & (s_de >= s_ae) & (s_de <= nom_w - s_ae);
wire ok_time = (stg_time_r >= `AWSQ_TIME_MIN) & (stg_time_r <= `AWSQ_TIME_MAX);
wire [39:0] df_sc = s_df * `AWSQ_RATIO_DEN;
wire [39:0] tm_sc = stg_time_r * `AWSQ_RATIO_NUM;
wire ok_rat  = (s_df == 14'd0) | (df_sc >= tm_sc);
wire ok_ach  = (s_da == 16'd0) | ({s_da, 16'h0000} >= {3'b000, stg_time_r});
wire [6:0] c_pt = i_pwdata[6:0];
wire ok_pt   = (c_pt != 7'd0) & (c_pt <= `AWSQ_NPTS);
wire ok_pnt  = ok_amp & ok_frq & ok_ang & ok_dc & ok_time & ok_rat & ok_ach;
wire commit_ok = wr_commit & idle_w & ok_pt & ok_pnt;
wire [6:0] b_first = i_pwdata[6:0];
wire [6:0] b_last  = i_pwdata[14:8];
wire [9:0] b_cyc   = i_pwdata[25:16];
wire ok_blk  = (b_first != 7'd0) & (b_first <= b_last) & (b_last <= `AWSQ_NPTS)
             & (b_cyc <= `AWSQ_MAX_CYC);
wire block_ok = wr_block & idle_w & ok_blk;
wire rej_ev   = (wr_commit & ~commit_ok) | (wr_block & ~block_ok);

// ----------------------------------------
// point memory
// ----------------------------------------
// point storage
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        for (i = 0; i < 99; i = i + 1)
            mem[i] <= {`AWSQ_TIME_DEF, 101'd0};
    end else if (commit_ok) begin
        mem[c_pt - 7'd1] <= {stg_time_r, s_de, s_ds, stg_ang_r, s_fe, s_fs, s_ae, s_as};
    end
end
wire [129:0] pt_w  = mem[pt_r - 7'd1];
wire [15:0]  p_as  = pt_w[15:0];
wire [15:0]  p_ae  = pt_w[31:16];
wire [13:0]  p_fs  = pt_w[45:32];
wire [13:0]  p_fe  = pt_w[59:46];
wire [8:0]   p_ang = pt_w[68:60];
wire [15:0]  p_ds  = pt_w[84:69];
wire [15:0]  p_de  = pt_w[100:85];
wire [28:0]  p_t   = pt_w[129:101];

// ----------------------------------------
// increment divider operands
// ----------------------------------------
reg [15:0] d_a;
reg [15:0] d_b;
always @* begin
    case (dsel_r)
        2'd0:    begin d_a = p_ds;          d_b = p_de;          end
        2'd1:    begin d_a = p_as;          d_b = p_ae;          end
        default: begin d_a = {2'b00, p_fs}; d_b = {2'b00, p_fe}; end
    endcase
end
wire        d_neg = (d_b < d_a);
wire [15:0] d_mag = d_neg ? d_a - d_b : d_b - d_a;
wire [29:0] d_sh  = {drem_r[28:0], dquo_r[31]};
wire        d_ge  = (d_sh >= {1'b0, p_t});
wire [32:0] q_s   = d_neg ? (~{1'b0, dquo_r} + 33'd1) : {1'b0, dquo_r};
// ----------------------------------------
// sine shaping
// ----------------------------------------
// parabola with one correction term: about 0.1 percent error, no table
wire [14:0] sx   = ph_r[30:16];
wire [30:0] sp   = {16'h0000, sx} * {15'h0000, 16'h8000 - {1'b0, sx}};
wire [15:0] y1   = sp[28:13];
wire [31:0] yy   = y1 * y1;
wire [15:0] ydf  = y1 - yy[30:15];
wire [31:0] ycr  = ydf * `AWSQ_SIN_CORR;
wire [15:0] ys   = y1 - {1'b0, ycr[29:15]};
wire [31:0] acm  = amp_acc_r[31:16] * ys;
wire        ac_on = (p_fs != 14'd0) | (p_fe != 14'd0);
wire [16:0] ac_w  = ac_on ? acm[31:15] : 17'd0;
wire [17:0] sum_w = ph_r[31] ? {2'b00, dc_acc_r[31:16]} - {1'b0, ac_w}
                             : {2'b00, dc_acc_r[31:16]} + {1'b0, ac_w};
wire [15:0] sat_w = sum_w[17] ? 16'd0 :
                    (sum_w[16:0] > {1'b0, nom_w}) ? nom_w : sum_w[15:0];
wire [45:0] pinc  = frq_acc_r[29:0] * `AWSQ_FRQ_TO_PH;
wire [32:0] ang_w = p_ang * `AWSQ_ANG_TO_PH;
wire        tick_w = (tick_r == SAMPLE_CYC - 1);
wire        pend_w = tick_w & (smp_r == p_t - 29'd1);
wire        lastc_w = (cyc_r != 10'd0) & (done_cyc_r + 10'd1 == cyc_r);
// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        st_r       <= ST_IDLE;
        pt_r       <= 7'd1;
        done_cyc_r <= 10'd0;
        // datapath registers are loaded before use, so they carry no reset
        o_setpoint <= 16'h0000;
    end else if (i_alarm | stop_w) begin
        st_r       <= ST_IDLE;
        o_setpoint <= 16'h0000;
    end else begin
        case (st_r)
            ST_IDLE: begin
                o_setpoint <= 16'h0000;
                if (start_w) begin
                    pt_r       <= first_r;
                    done_cyc_r <= 10'd0;
                    dsel_r     <= 2'd0;
                    dcnt_r     <= 6'd0;
                    st_r       <= ST_LOAD;
                end
            end
            ST_LOAD: begin
                dcnt_r <= (dcnt_r == 6'd33) ? 6'd0 : dcnt_r + 6'd1;
                if (dcnt_r == 6'd0) begin
                    dquo_r <= {d_mag, 16'h0000};
                    drem_r <= 30'd0;
                    if (dsel_r == 2'd0) begin
                        dc_acc_r  <= {1'b0, p_ds, 16'h0000};
                        amp_acc_r <= {1'b0, p_as, 16'h0000};
                        frq_acc_r <= {3'b000, p_fs, 16'h0000};
                        ph_r      <= ang_w[31:0];
                    end
                end else if (dcnt_r <= 6'd32) begin
                    drem_r <= d_ge ? d_sh - {1'b0, p_t} : d_sh;
                    dquo_r <= {dquo_r[30:0], d_ge};
                end else begin
                    case (dsel_r)
                        2'd0:    dc_inc_r  <= q_s;
                        2'd1:    amp_inc_r <= q_s;
                        default: frq_inc_r <= q_s;
                    endcase
                    tick_r <= 32'h0000_0000;
                    smp_r  <= 29'd0;
                    dsel_r <= dsel_r + 2'd1;
                    if (dsel_r == 2'd2)
                        st_r <= ST_RUN;
                end
            end
            ST_RUN: begin
                o_setpoint <= sat_w;
                tick_r     <= tick_w ? 32'h0000_0000 : tick_r + 32'h0000_0001;
                if (tick_w) begin
                    smp_r     <= smp_r + 29'd1;
                    dc_acc_r  <= dc_acc_r + dc_inc_r;
                    amp_acc_r <= amp_acc_r + amp_inc_r;
                    frq_acc_r <= frq_acc_r + frq_inc_r;
                    ph_r      <= ph_r + pinc[44:13];
                end
                if (pend_w) begin
                    dsel_r <= 2'd0;
                    dcnt_r <= 6'd0;
                    if (pt_r != last_r) begin
                        pt_r <= pt_r + 7'd1;
                        st_r <= ST_LOAD;
                    end else if (lastc_w) begin
                        st_r       <= ST_IDLE;
                        o_setpoint <= 16'h0000;
                    end else begin
                        done_cyc_r <= done_cyc_r + 10'd1;
                        pt_r       <= first_r;
                        st_r       <= ST_LOAD;
                    end
                end
            end
            default: st_r <= ST_IDLE;
        endcase
    end
end
wire done_ev = (st_r == ST_RUN) & pend_w & (pt_r == last_r) & lastc_w
             & ~i_alarm & ~stop_w;
wire alm_ev  = i_alarm & ~idle_w;
// ----------------------------------------
// software registers
// ----------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        volt_r     <= 1'b0;
        first_r    <= 7'd1;
        last_r     <= 7'd1;
        cyc_r      <= 10'd1;
        istat_r    <= 3'd0;
        imask_r    <= 3'd0;
        stg_amp_r  <= 32'h0000_0000;
        stg_frq_r  <= 32'h0000_0000;
        stg_dc_r   <= 32'h0000_0000;
        stg_time_r <= `AWSQ_TIME_DEF;
        stg_ang_r  <= 9'd0;
    end else begin
        if (wr_ctrl & idle_w)
            volt_r <= i_pwdata[`AWSQ_CTRL_VOLT];
        if (block_ok) begin
            first_r <= b_first;
            last_r  <= b_last;
            cyc_r   <= b_cyc;
        end
        if (wr_w & (i_paddr == `AWSQ_IMASK)) imask_r <= i_pwdata[2:0];
        if (wr_w & (i_paddr == `AWSQ_AMP)) stg_amp_r <= i_pwdata;
        if (wr_w & (i_paddr == `AWSQ_FREQ))
            stg_frq_r <= {2'b00, i_pwdata[29:16], 2'b00, i_pwdata[13:0]};
        if (wr_w & (i_paddr == `AWSQ_DC)) stg_dc_r <= i_pwdata;
        if (wr_w & (i_paddr == `AWSQ_TIME)) stg_time_r <= i_pwdata[28:0];
        if (wr_w & (i_paddr == `AWSQ_ANGLE)) stg_ang_r <= i_pwdata[8:0];
        // a new event outranks a clear in the same cycle
        istat_r <= (istat_r & ~((wr_w & (i_paddr == `AWSQ_ISTAT)) ? i_pwdata[2:0] : 3'd0))
                 | {alm_ev, rej_ev, done_ev};
    end
end

// ----------------------------------------
// read data, captured in the setup phase
// ----------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable) begin
        case (i_paddr)
            `AWSQ_CTRL:  o_prdata <= {29'd0, volt_r, 2'b00};
            `AWSQ_STAT:  o_prdata <= {6'd0, done_cyc_r, 1'b0, pt_r, 6'd0, st_r};
            `AWSQ_ISTAT: o_prdata <= {29'd0, istat_r};
            `AWSQ_IMASK: o_prdata <= {29'd0, imask_r};
            `AWSQ_BLOCK: o_prdata <= {6'd0, cyc_r, 1'b0, last_r, 1'b0, first_r};
            `AWSQ_AMP:   o_prdata <= stg_amp_r;
            `AWSQ_FREQ:  o_prdata <= stg_frq_r;
            `AWSQ_DC:    o_prdata <= stg_dc_r;
            `AWSQ_TIME:  o_prdata <= {3'b000, stg_time_r};
            `AWSQ_ANGLE: o_prdata <= {23'd0, stg_ang_r};
            `AWSQ_SETPT: o_prdata <= {16'h0000, o_setpoint};
            default:     o_prdata <= 32'h0000_0000;
        endcase
    end
end
assign o_output_on   = (st_r != ST_IDLE);
assign o_sel_voltage = volt_r;
assign o_irq         = |(istat_r & imask_r);

endmodule // awsq_top

// File: awsq_checker.sv
`timescale 1ns/1ps
`include "awsq_consts.vh"
// ----------------------------------------
// port-level checks
// ----------------------------------------
module awsq_checker #(
    parameter [15:0] NOM_VOLT = 16'hffff,
    parameter [15:0] NOM_CURR = 16'hffff
) (
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire        i_alarm,
    input wire [15:0] o_setpoint,
    input wire        o_sel_voltage,
    input wire        o_output_on,
    input wire        o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_ctrl_wr;
        i_psel && i_penable && i_pwrite && i_paddr == `AWSQ_CTRL;
    endsequence
    sequence s_start;
        s_ctrl_wr ##0 (i_pwdata[0] && !i_pwdata[1] && !i_alarm && !o_output_on);
    endsequence
    sequence s_stop;
        s_ctrl_wr ##0 i_pwdata[1];
    endsequence
    sequence s_setpt_rd;
        i_psel && !i_penable && !i_pwrite && i_paddr == `AWSQ_SETPT;
    endsequence
    AST_IDLE_ZERO: assert property (!o_output_on |-> o_setpoint == 16'h0000)
        else $error("setpoint not zero while output off");
    AST_ALARM_HALT: assert property (i_alarm |=> !o_output_on && o_setpoint == 16'h0000)
        else $error("alarm did not halt the run");
    AST_STOP_HALT: assert property (s_stop |=> !o_output_on)
        else $error("stop did not halt the run");
    AST_START_RUN: assert property (s_start |=> o_output_on)
        else $error("start did not switch the output on");
    AST_MODE_HOLD: assert property (o_output_on |=> $stable(o_sel_voltage))
        else $error("quantity changed during a run");
    AST_LOAD_HOLD: assert property ($rose(o_output_on) |-> (o_setpoint == 16'h0000) [*8])
        else $error("setpoint moved during point load");
    AST_RANGE: assert property (o_setpoint <= (o_sel_voltage ? NOM_VOLT : NOM_CURR))
        else $error("setpoint above nominal");
    AST_SETPT_RD: assert property (s_setpt_rd |=> o_prdata == {16'h0000, $past(o_setpoint)})
        else $error("setpoint readback differs from output");
endmodule // awsq_checker

bind awsq_top awsq_checker #(.NOM_VOLT(NOM_VOLT), .NOM_CURR(NOM_CURR)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_alarm(i_alarm),
    .o_setpoint(o_setpoint), .o_sel_voltage(o_sel_voltage), .o_output_on(o_output_on),
    .o_irq(o_irq));

// File: awsq_stage_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// power stage setpoint input
// ----------------------------------------
module awsq_stage_model (
    // from the sequencer
    input  wire        i_clk,
    input  wire [15:0] i_setpoint,
    input  wire        i_sel_voltage,
    input  wire        i_output_on,
    // observed state
    output logic [15:0] o_applied,
    output int          o_bad
);
    logic sel_r = 1'b0;
    initial o_applied = 16'h0000;
    initial o_bad = 0;
    // off means zero
    // stage follows the setpoint only while on; one quantity per run
    always @(posedge i_clk) begin
        sel_r <= i_sel_voltage;
        if (i_output_on) begin
            o_applied <= i_setpoint;
            if (sel_r != i_sel_voltage)
                o_bad <= o_bad + 1;
        end else if (i_setpoint != 16'h0000)
            o_bad <= o_bad + 1;
    end
endmodule // awsq_stage_model

// File: awsq_top_tb.sv
`timescale 1ns/1ps
`include "awsq_consts.vh"
module awsq_top_tb;
    localparam [15:0] NOM_V = 16'h4000;
    localparam [15:0] NOM_I = 16'h8000;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, alarm = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, sel_v, out_on, irq, serr;
    logic [15:0] setpt, applied;
    int          bad, err_total = 0, checked = 0;

    always #5 clk = ~clk;

    awsq_top #(.SAMPLE_CYC(8), .NOM_VOLT(NOM_V), .NOM_CURR(NOM_I)) DUT (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_alarm(alarm), .o_setpoint(setpt),
        .o_sel_voltage(sel_v), .o_output_on(out_on), .o_irq(irq));
    awsq_stage_model u_stage (.i_clk(clk), .i_setpoint(setpt), .i_sel_voltage(sel_v),
        .i_output_on(out_on), .o_applied(applied), .o_bad(bad));

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // an idle edge first, so a new setup never lands on the release edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d; pen <= 0;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                chk("pready wait", 1, 0);
                tally_and_finish;
            end
            @(posedge clk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask
    task set_pt(input logic [31:0] am, fr, dc, tm, an, pt);
        wr(`AWSQ_AMP, am); wr(`AWSQ_FREQ, fr); wr(`AWSQ_DC, dc);
        wr(`AWSQ_TIME, tm); wr(`AWSQ_ANGLE, an); wr(`AWSQ_COMMIT, pt);
    endtask
    task try_cfg(input logic [31:0] am, fr, dc, tm, an, input logic rej);
        wr(`AWSQ_ISTAT, 32'h0000_0007);
        set_pt(am, fr, dc, tm, an, 32'h0000_0063);
        rdc("cfg reject", `AWSQ_ISTAT, {30'h0, rej, 1'b0});
    endtask
    task try_blk(input logic [31:0] d, input logic rej);
        wr(`AWSQ_ISTAT, 32'h0000_0007);
        wr(`AWSQ_BLOCK, d);
        rdc("block reject", `AWSQ_ISTAT, {30'h0, rej, 1'b0});
        chk("irq", rej, irq);
    endtask
    task wait_run(input logic [6:0] p);
        int n;
        for (n = 0; n < 200; n++) begin
            apb(0, `AWSQ_STAT, 32'h0000_0000);
            if (rd[1:0] == 2'd2 && rd[14:8] == p)
                return;
        end
        chk("run wait", 1, 0);
        tally_and_finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rdc("block", `AWSQ_BLOCK, `AWSQ_BLOCK_RST);
        rdc("stat", `AWSQ_STAT, 32'h0000_0100);
        rdc("imask", `AWSQ_IMASK, 32'h0000_0000);
        apb(0, 12'h0fc, 32'h0000_0000);
        chk("unmapped err", 1, serr);
        chk("idle setpoint", 0, setpt);
    endtask
    task t_reject;
        wr(`AWSQ_IMASK, 32'h0000_0007);
        try_blk(32'h0001_0100, 1);
        try_blk(32'h0001_0102, 1);
        try_blk(32'h0001_6301, 0);
        try_blk(32'h0001_6401, 1);
        try_blk(32'h03e7_0101, 0);
        try_blk(32'h03e8_0101, 1);
        try_blk(32'h0000_0101, 0);
        wr(`AWSQ_IMASK, 32'h0000_0000);
        wr(`AWSQ_BLOCK, 32'h0001_0100);
        rdc("masked status", `AWSQ_ISTAT, 32'h0000_0002);
        chk("masked irq", 0, irq);
        try_cfg(32'h4000_4000, 0, 32'h4000_4000, 10, 0, 0);
        try_cfg(32'h4001_4001, 0, 32'h4000_4000, 10, 0, 1);
        try_cfg(0, 32'h2710_2710, 32'h1000_1000, 10, 0, 0);
        try_cfg(0, 32'h2711_2711, 32'h1000_1000, 10, 0, 1);
        try_cfg(0, 0, 32'h1000_1000, 10, 359, 0);
        try_cfg(0, 0, 32'h1000_1000, 10, 360, 1);
        try_cfg(32'h0100_0100, 0, 32'h7f00_0100, 10, 0, 0);
        try_cfg(32'h0100_0100, 0, 32'h7f01_0100, 10, 0, 1);
        try_cfg(32'h0100_0100, 0, 32'h1000_00ff, 10, 0, 1);
        try_cfg(0, 0, 32'h1000_1000, 0, 0, 1);
        try_cfg(0, 0, 32'h1000_1000, 32'h1575_2a00, 0, 0);
        try_cfg(0, 0, 32'h1000_1000, 32'h1575_2a01, 0, 1);
        try_cfg(0, 32'h000b_0001, 32'h1000_1000, 10752, 0, 0);
        try_cfg(0, 32'h000b_0001, 32'h1000_1000, 10753, 0, 1);
        try_cfg(32'h0101_0100, 0, 32'h1000_1000, 65536, 0, 0);
        try_cfg(32'h0101_0100, 0, 32'h1000_1000, 65537, 0, 1);
        wr(`AWSQ_CTRL, 32'h0000_0004);
        try_cfg(32'h2001_2001, 0, 32'h4000_4000, 10, 0, 1);
        try_cfg(32'h2000_2000, 0, 32'h2000_2000, 10, 0, 0);
        wr(`AWSQ_CTRL, 32'h0000_0000);
    endtask
    task t_run;
        int c, p, n;
        set_pt(0, 0, 32'h1000_1000, 4, 0, 1);
        set_pt(0, 0, 32'h2000_2000, 4, 0, 2);
        wr(`AWSQ_BLOCK, 32'h0002_0201);
        wr(`AWSQ_ISTAT, 32'h0000_0007);
        wr(`AWSQ_IMASK, 32'h0000_0001);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        wr(`AWSQ_CTRL, 32'h0000_0004);
        chk("mode in run", 0, sel_v);
        for (c = 0; c < 2; c++)
            for (p = 1; p < 3; p++) begin
                wait_run(p[6:0]);
                rdc("flat dc", `AWSQ_SETPT, p * 32'h0000_1000);
            end
        for (n = 0; n < 400 && out_on === 1'b1; n++)
            @(posedge clk);
        chk("run ended", 0, out_on);
        chk("last applied", 16'h2000, applied);
        rdc("done", `AWSQ_ISTAT, 32'h0000_0001);
        chk("done irq", 1, irq);
        wr(`AWSQ_CTRL, 32'h0000_0004);
        @(posedge clk);
        chk("mode volt", 1, sel_v);
        rdc("ctrl mode", `AWSQ_CTRL, 32'h0000_0004);
        wr(`AWSQ_CTRL, 32'h0000_0000);
    endtask
    task t_sine;
        set_pt(32'h1000_1000, 32'h0001_0001, 32'h4000_4000, 4, 90, 3);
        wr(`AWSQ_BLOCK, 32'h0001_0303);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        wait_run(7'd3);
        apb(0, `AWSQ_SETPT, 32'h0000_0000);
        chk("sine peak", 1, rd >= 32'h0000_4f00 && rd <= 32'h0000_5000);
        wr(`AWSQ_CTRL, 32'h0000_0002);
        set_pt(32'h1000_1000, 0, 32'h4000_4000, 4, 90, 3);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        wait_run(7'd3);
        rdc("no sine", `AWSQ_SETPT, 32'h0000_4000);
        wr(`AWSQ_CTRL, 32'h0000_0002);
    endtask
    task t_alarm;
        wr(`AWSQ_ISTAT, 32'h0000_0007);
        wr(`AWSQ_IMASK, 32'h0000_0004);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        alarm <= 1;
        repeat (2) @(posedge clk);
        chk("alarm off", 0, out_on);
        rdc("alarm flag", `AWSQ_ISTAT, 32'h0000_0004);
        chk("alarm irq", 1, irq);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        @(posedge clk);
        chk("start in alarm", 0, out_on);
        alarm <= 0;
        wr(`AWSQ_ISTAT, 32'h0000_0007);
        wr(`AWSQ_CTRL, 32'h0000_0001);
        wr(`AWSQ_CTRL, 32'h0000_0002);
        @(posedge clk);
        chk("stopped", 0, out_on);
        rdc("stop no event", `AWSQ_ISTAT, 32'h0000_0000);
        chk("stage", 0, bad);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        t_reset;
        t_reject;
        t_run;
        t_sine;
        t_alarm;
        tally_and_finish;
    end
endmodule // awsq_top_tb
